// ---- hw/slm_pkg.sv ----
/*
  Package for the synthetic loss measurement endpoint: register map,
  field layout, reset values and the lookup request and result carriers.
  Assumes a 32-bit classic Wishbone slave with byte addresses.
*/
package slm_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_SESSION  = 8'h04;
  localparam logic [7:0] OFF_TESTID   = 8'h08;
  localparam logic [7:0] OFF_STICKY   = 8'h0C;
  localparam logic [7:0] OFF_TXFRMCNT = 8'h10;
  localparam logic [7:0] OFF_EXTRACT  = 8'h14;
  localparam logic [7:0] OFF_OAMTX    = 8'h18;
  localparam logic [7:0] OFF_OAMRX    = 8'h1C;
  localparam logic [7:0] OFF_PEER     = 8'h20;
  localparam logic [7:0] OFF_TXLOSS   = 8'h40;
  localparam logic [7:0] OFF_RXLOSS   = 8'h60;

  // ==========================================================================
  // Field positions
  localparam int CTRL_SYNTH_LOSS_ENABLE   = 0;
  localparam int CTRL_REQ_HW   = 1;
  localparam int CTRL_REP_HW   = 2;
  localparam int CTRL_REQ_OAM  = 3;
  localparam int CTRL_REP_OAM  = 4;
  localparam int CTRL_REQ_LB   = 5;
  localparam int CTRL_REQ_CPU  = 6;
  localparam int CTRL_REP_CPU  = 7;
  localparam int CTRL_REWRITE  = 8;
  localparam int CTRL_ERR_EXTR = 9;
  localparam int SES_OWNID_LSB = 16;
  localparam int PEER_VLD_BIT  = 16;
  localparam int EXT_HMO_BIT   = 8;
  localparam int STK_REQ_RX    = 0;
  localparam int STK_REP_RX    = 1;
  localparam int STK_ONE_RX    = 2;
  localparam int STK_TX_PRIO   = 3;
  localparam int STK_TX_PEER   = 4;
  localparam int STK_RX_PRIO   = 5;
  localparam int STK_RX_PEER   = 6;
  localparam int STK_RX_SES    = 7;

  // ==========================================================================
  // Sizes, reset values and PDU constants
  localparam int NUM_PEERS = 8;
  localparam logic [9:0]  RST_CTRL    = 10'h000;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [7:0]  SLR_TLV_OFS = 8'h14;
  localparam logic [7:0]  END_TLV     = 8'h00;

  typedef enum logic [1:0] {
    SLM_PDU_REQ = 2'b00,
    SLM_PDU_REP = 2'b01,
    SLM_PDU_ONE = 2'b11
  } slm_pdu_e;

  typedef struct packed {
    logic        vld;
    logic        txDir;
    slm_pdu_e    pdu;
    logic [2:0]  prio;
    logic [12:0] srcId;
    logic [12:0] rspId;
    logic [31:0] testId;
  } slm_req_s;

  typedef struct packed {
    logic        vld;
    logic        frmValid;
    logic [2:0]  peerIdx;
    logic        fieldWr;
    logic [31:0] fieldVal;
    logic        rspWr;
    logic [12:0] rspId;
    logic        rewrite;
    logic [7:0]  tlvOffset;
    logic [7:0]  endTlv;
    logic        loopInject;
    logic        cpuCopy;
    logic        errExtract;
  } slm_res_s;

endpackage

// ---- hw/slm_endpoint.sv ----
/*
  Synthetic loss measurement for one OAM endpoint: validates request,
  reply and one-way frames from the Tx and Rx lookups, keeps the frame and
  per-peer loss counters and tells the pipeline how to modify each frame.
  Assumes one lookup request per cycle at most, from logic on clk_sys, and
  a classic Wishbone master for the registers.
*/
// Summary of operation
// RQ1 - Enable bit plus eight-entry peer table
// RQ2 - Session test id, own id, one priority
// RQ3 - Tx reply needs source id in peers
// RQ4 - Tx priority must match session priority
// RQ5 - Failed frames optionally go to error queue
// RQ6 - Rx request/one-way: peer listed, priority matches
// RQ7 - Rx reply: source equals own id, priority (source checked only with CTRL_REP_HW set)
// RQ8 - Rx reply: responder listed, test id matches (test id checked only with CTRL_REP_HW set)
// RQ9 - Separate hardware enables; disabled frames untouched
// RQ10 - Separate OAM count enables; loss always counted
// RQ11 - Tx request carries frame count, then increments
// RQ12 - Rx request sets flag, optional loopback
// RQ13 - Request copy to CPU from any peer
// RQ14 - Tx reply carries peer Tx count, increments
// RQ15 - Tx reply responder id becomes own id
// RQ16 - Rx reply sets flag, samples peer count
// RQ17 - Rewrite sets TLV offset twenty, end TLV
// RQ18 - Rewrite inserts prior Rx count, then increments
// RQ19 - Per-peer extract, optionally first hit only
// RQ20 - Reply copy to CPU from any peer
// RQ21 - Tx one-way carries frame count, increments
// RQ22 - Rx one-way flag, count into reserved field
// RQ23 - Peer index is matching table row
// RQ24 - Counters are 32 bits and wrap
`timescale 1ns/10ps

module slm_endpoint (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Wishbone slave
  input  wire logic             wbCyc,
  input  wire logic             wbStb,
  input  wire logic             wbWe,
  input  wire logic [7:0]       wbAdr,
  input  wire logic [3:0]       wbSel,
  input  wire logic [31:0]      wbDatW,
  output logic      [31:0]      wbDatR,
  output logic                  wbAck,
  // Frame pipeline lookups
  input  wire slm_pkg::slm_req_s lkReq,
  output slm_pkg::slm_res_s      lkRes
);

  // ==========================================================================
  // Decoding helpers
  function automatic logic slm_at(input logic [7:0] adr, input logic [7:0] off);
    slm_at = (adr == off);
  endfunction

  function automatic logic [31:0] slm_bytes(input logic [31:0] old,
                                            input logic [31:0] nxt,
                                            input logic [3:0]  sel);
    for (int b = 0; b < 4; b++) begin
      slm_bytes[b*8 +: 8] = sel[b] ? nxt[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // ==========================================================================
  // State
  logic [9:0]  ctrl_q;
  logic [2:0]  sessPrio_q;
  logic [12:0] ownId_q;
  logic [31:0] testId_q;
  logic [7:0]  sticky_q;
  logic [7:0]  sticky_d;
  logic [31:0] txFrameCount_q;
  logic [31:0] oamTx_q;
  logic [31:0] oamRx_q;
  logic [7:0]  extMask_q;
  logic        extHmo_q;
  logic [7:0]  peerVld_q;
  logic [12:0] peerId_q   [slm_pkg::NUM_PEERS];
  logic [31:0] txLoss_q   [slm_pkg::NUM_PEERS];
  logic [31:0] rxLoss_q   [slm_pkg::NUM_PEERS];

  logic        wbWr;
  logic        wbRd;
  logic        bad;
  logic        prioOk;
  logic        peerOk;
  logic        sesOk;
  logic        frmOk;
  logic        isReq;
  logic        isRep;
  logic        hwEna;
  logic [2:0]  idx;
  logic        srcHit;
  logic [2:0]  srcIdx;
  logic        rspHit;
  logic [2:0]  rspIdx;
  logic [7:0]  stkSet;
  logic        extHit;

  assign wbWr = wbCyc & wbStb & wbWe & ~wbAck;
  assign wbRd = wbCyc & wbStb & ~wbWe & ~wbAck;

  // ==========================================================================
  // Peer lookup: lowest enabled row whose id matches
  always_comb begin
    srcHit = 1'b0;
    srcIdx = 3'h0;
    rspHit = 1'b0;
    rspIdx = 3'h0;
    for (int p = slm_pkg::NUM_PEERS - 1; p >= 0; p--) begin
      if (peerVld_q[p] && peerId_q[p] == lkReq.srcId) begin  // [RQ23]
        srcHit = 1'b1;
        srcIdx = 3'(p);
      end
      if (peerVld_q[p] && peerId_q[p] == lkReq.rspId) begin
        rspHit = 1'b1;
        rspIdx = 3'(p);
      end
    end
  end

  // ==========================================================================
  // Validation
  always_comb begin
    isReq  = (lkReq.pdu == slm_pkg::SLM_PDU_REQ);
    isRep  = (lkReq.pdu == slm_pkg::SLM_PDU_REP);
    hwEna  = isReq ? ctrl_q[slm_pkg::CTRL_REQ_HW] : ctrl_q[slm_pkg::CTRL_REP_HW];  // [RQ9]
    prioOk = (lkReq.prio == sessPrio_q);  // [RQ4] [RQ6] [RQ7]
    sesOk  = 1'b1;
    idx    = srcIdx;
    if (lkReq.txDir) begin
      peerOk = !isRep || srcHit;  // [RQ3]
    end else if (isRep) begin
      peerOk = rspHit;  // [RQ8]
      idx    = rspIdx;
      // With reply processing off only the peer and priority are checked
      sesOk  = !hwEna || (lkReq.srcId == ownId_q && lkReq.testId == testId_q);  // [RQ7] [RQ8]
    end else begin
      peerOk = srcHit;  // [RQ6]
    end
    bad    = lkReq.vld && ctrl_q[slm_pkg::CTRL_SYNTH_LOSS_ENABLE] && !(prioOk && peerOk && sesOk);
    frmOk  = lkReq.vld && ctrl_q[slm_pkg::CTRL_SYNTH_LOSS_ENABLE] && prioOk && peerOk && sesOk;  // [RQ1]
    extHit = extMask_q[idx];
  end

  // ==========================================================================
  // Sticky flags: hardware set wins over a write-one-to-clear
  always_comb begin
    stkSet = 8'h00;
    stkSet[slm_pkg::STK_REQ_RX]  = frmOk && !lkReq.txDir && isReq;  // [RQ12]
    stkSet[slm_pkg::STK_REP_RX]  = frmOk && !lkReq.txDir && isRep;  // [RQ16]
    stkSet[slm_pkg::STK_ONE_RX]  = frmOk && !lkReq.txDir && !isReq && !isRep;  // [RQ22]
    stkSet[slm_pkg::STK_TX_PRIO] = bad && lkReq.txDir && !prioOk;  // [RQ4]
    stkSet[slm_pkg::STK_TX_PEER] = bad && lkReq.txDir && !peerOk;
    stkSet[slm_pkg::STK_RX_PRIO] = bad && !lkReq.txDir && !prioOk;
    stkSet[slm_pkg::STK_RX_PEER] = bad && !lkReq.txDir && !peerOk;
    stkSet[slm_pkg::STK_RX_SES]  = bad && !lkReq.txDir && !sesOk;
    sticky_d = sticky_q;
    if (wbWr && slm_at(wbAdr, slm_pkg::OFF_STICKY) && wbSel[0]) begin
      sticky_d = sticky_q & ~wbDatW[7:0];
    end
    sticky_d = sticky_d | stkSet;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sticky_q <= 8'h00;
    end else begin
      sticky_q <= sticky_d;
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q     <= slm_pkg::RST_CTRL;
      sessPrio_q <= 3'h0;
      ownId_q    <= 13'h0000;
      testId_q   <= slm_pkg::RST_WORD;
    end else if (wbWr) begin
      if (slm_at(wbAdr, slm_pkg::OFF_CTRL)) begin
        ctrl_q <= 10'(slm_bytes({22'h000000, ctrl_q}, wbDatW, wbSel));  // [RQ1] [RQ9]
      end
      if (slm_at(wbAdr, slm_pkg::OFF_SESSION)) begin
        sessPrio_q <= wbSel[0] ? wbDatW[2:0] : sessPrio_q;  // [RQ2]
        ownId_q    <= 13'(slm_bytes({3'h0, ownId_q, 16'h0000}, wbDatW, wbSel) >> 16);
      end
      if (slm_at(wbAdr, slm_pkg::OFF_TESTID)) begin
        testId_q <= slm_bytes(testId_q, wbDatW, wbSel);
      end
    end
  end

  // Peer extract mask: first-hit-only clears the peer's bit after a copy
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      extMask_q <= 8'h00;
      extHmo_q  <= 1'b0;
    end else if (wbWr && slm_at(wbAdr, slm_pkg::OFF_EXTRACT)) begin
      extMask_q <= wbSel[0] ? wbDatW[7:0] : extMask_q;
      extHmo_q  <= wbSel[1] ? wbDatW[slm_pkg::EXT_HMO_BIT] : extHmo_q;
    end else if (frmOk && !lkReq.txDir && !isReq && extHit && extHmo_q) begin
      extMask_q[idx] <= 1'b0;  // [RQ19]
    end
  end

  // ==========================================================================
  // Shared initiator frame counter; hardware increment wins over a write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      txFrameCount_q <= slm_pkg::RST_WORD;
    end else if (frmOk && lkReq.txDir && !isRep) begin
      txFrameCount_q <= txFrameCount_q + 32'h0000_0001;  // [RQ11] [RQ21] [RQ24]
    end else if (wbWr && slm_at(wbAdr, slm_pkg::OFF_TXFRMCNT)) begin
      txFrameCount_q <= slm_bytes(txFrameCount_q, wbDatW, wbSel);
    end
  end

  // OAM frame counters, one enable for requests and one for replies/one-way
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      oamTx_q <= slm_pkg::RST_WORD;
      oamRx_q <= slm_pkg::RST_WORD;
    end else if (frmOk && (isReq ? ctrl_q[slm_pkg::CTRL_REQ_OAM]
                                 : ctrl_q[slm_pkg::CTRL_REP_OAM])) begin  // [RQ10]
      oamTx_q <= lkReq.txDir ? oamTx_q + 32'h0000_0001 : oamTx_q;
      oamRx_q <= lkReq.txDir ? oamRx_q : oamRx_q + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // Peer table and per-peer loss counters
  generate
    for (genvar g = 0; g < slm_pkg::NUM_PEERS; g++) begin : gPeer
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          peerVld_q[g] <= 1'b0;
          peerId_q[g]  <= 13'h0000;
        end else if (wbWr && slm_at(wbAdr, slm_pkg::OFF_PEER + 8'(4 * g))) begin
          peerId_q[g]  <= 13'(slm_bytes({19'h00000, peerId_q[g]}, wbDatW, wbSel));
          peerVld_q[g] <= wbSel[2] ? wbDatW[slm_pkg::PEER_VLD_BIT] : peerVld_q[g];
        end
      end

      // Loss counters always count valid frames, whatever the hardware enables
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          txLoss_q[g] <= slm_pkg::RST_WORD;
        end else if (frmOk && lkReq.txDir && isRep && idx == 3'(g)) begin
          txLoss_q[g] <= txLoss_q[g] + 32'h0000_0001;  // [RQ10] [RQ14] [RQ24]
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          rxLoss_q[g] <= slm_pkg::RST_WORD;
        end else if (frmOk && !lkReq.txDir && !isReq && idx == 3'(g)) begin
          rxLoss_q[g] <= rxLoss_q[g] + 32'h0000_0001;  // [RQ18] [RQ22] [RQ24]
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Lookup result, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lkRes <= '0;
    end else begin
      lkRes.vld      <= lkReq.vld;
      lkRes.frmValid <= frmOk;
      lkRes.peerIdx  <= idx;  // [RQ23]
      lkRes.rspId    <= ownId_q;
      lkRes.endTlv   <= slm_pkg::END_TLV;
      lkRes.tlvOffset <= slm_pkg::SLR_TLV_OFS;
      // Sampled value is the count before this frame is counted
      if (lkReq.txDir) begin
        lkRes.fieldVal <= isRep ? txLoss_q[idx] : txFrameCount_q;  // [RQ11] [RQ14] [RQ21]
      end else begin
        lkRes.fieldVal <= rxLoss_q[idx];  // [RQ16] [RQ18] [RQ22]
      end
      lkRes.rewrite  <= frmOk && hwEna && !lkReq.txDir && isRep
                        && ctrl_q[slm_pkg::CTRL_REWRITE];  // [RQ17]
      lkRes.fieldWr  <= frmOk && hwEna && (lkReq.txDir || !isReq)
                        && (lkReq.txDir || !isRep || ctrl_q[slm_pkg::CTRL_REWRITE]);  // [RQ9]
      lkRes.rspWr    <= lkReq.vld && ctrl_q[slm_pkg::CTRL_SYNTH_LOSS_ENABLE] && lkReq.txDir
                        && isRep && hwEna;  // [RQ15]
      lkRes.loopInject <= frmOk && !lkReq.txDir && isReq
                          && ctrl_q[slm_pkg::CTRL_REQ_LB];  // [RQ12]
      lkRes.cpuCopy  <= frmOk && !lkReq.txDir
                        && ((isReq && ctrl_q[slm_pkg::CTRL_REQ_CPU])  // [RQ13]
                        || (!isReq && ctrl_q[slm_pkg::CTRL_REP_CPU])  // [RQ20]
                        || (!isReq && extHit));  // [RQ19]
      lkRes.errExtract <= bad && ctrl_q[slm_pkg::CTRL_ERR_EXTR];  // [RQ5]
    end
  end

  // ==========================================================================
  // Wishbone answer: ack one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wbAck <= 1'b0;
    end else begin
      wbAck <= wbCyc & wbStb & ~wbAck;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wbDatR <= slm_pkg::RST_WORD;
    end else if (wbRd) begin
      wbDatR <= slm_pkg::RST_WORD;
      if (slm_at(wbAdr, slm_pkg::OFF_CTRL))     wbDatR <= {22'h000000, ctrl_q};
      if (slm_at(wbAdr, slm_pkg::OFF_SESSION))  wbDatR <= {3'h0, ownId_q, 13'h0000, sessPrio_q};
      if (slm_at(wbAdr, slm_pkg::OFF_TESTID))   wbDatR <= testId_q;
      if (slm_at(wbAdr, slm_pkg::OFF_STICKY))   wbDatR <= {24'h000000, sticky_q};
      if (slm_at(wbAdr, slm_pkg::OFF_TXFRMCNT)) wbDatR <= txFrameCount_q;
      if (slm_at(wbAdr, slm_pkg::OFF_EXTRACT))  wbDatR <= {23'h000000, extHmo_q, extMask_q};
      if (slm_at(wbAdr, slm_pkg::OFF_OAMTX))    wbDatR <= oamTx_q;
      if (slm_at(wbAdr, slm_pkg::OFF_OAMRX))    wbDatR <= oamRx_q;
      for (int p = 0; p < slm_pkg::NUM_PEERS; p++) begin
        if (slm_at(wbAdr, slm_pkg::OFF_PEER + 8'(4 * p))) begin
          wbDatR <= {15'h0000, peerVld_q[p], 3'h0, peerId_q[p]};
        end
        if (slm_at(wbAdr, slm_pkg::OFF_TXLOSS + 8'(4 * p))) wbDatR <= txLoss_q[p];
        if (slm_at(wbAdr, slm_pkg::OFF_RXLOSS + 8'(4 * p))) wbDatR <= rxLoss_q[p];
      end
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_TX_REQ_COUNT: assert property (  // [RQ11]
    frmOk && lkReq.txDir && isReq |=> txFrameCount_q == $past(txFrameCount_q) + 32'h0000_0001
      && lkRes.fieldVal == $past(txFrameCount_q))
    else $error("Tx request count not carried or not incremented");
  AST_TX_PRIO: assert property (  // [RQ4]
    lkReq.vld && lkReq.txDir && lkReq.prio != sessPrio_q |=> !lkRes.frmValid)
    else $error("Tx frame with wrong priority was accepted");
  AST_TX_PEER: assert property (  // [RQ3]
    lkReq.vld && lkReq.txDir && isRep && !srcHit |=> !lkRes.frmValid && !lkRes.fieldWr)
    else $error("Tx reply from unknown peer was accepted");
  AST_RSP_ID: assert property (  // [RQ15]
    lkReq.vld && lkReq.txDir && isRep && hwEna && ctrl_q[slm_pkg::CTRL_SYNTH_LOSS_ENABLE]
      |=> lkRes.rspWr && lkRes.rspId == $past(ownId_q))
    else $error("Responder id differs from own id");
  AST_RX_OWNID: assert property (  // [RQ7]
    lkReq.vld && !lkReq.txDir && isRep && hwEna && lkReq.srcId != ownId_q
      |=> !lkRes.frmValid ##1 sticky_q[slm_pkg::STK_RX_SES] || !ctrl_q[slm_pkg::CTRL_SYNTH_LOSS_ENABLE])
    else $error("Rx reply with foreign source id was accepted");
  AST_LOOP: assert property (  // [RQ12]
    lkRes.loopInject |-> lkRes.frmValid ##1 sticky_q[slm_pkg::STK_REQ_RX])
    else $error("Loopback without valid request frame");
  AST_REWRITE: assert property (  // [RQ17]
    lkRes.rewrite |-> lkRes.tlvOffset == 8'h14 && lkRes.endTlv == 8'h00 && lkRes.fieldWr)
    else $error("Reply rewrite fields wrong");
  AST_ERR_EXTR: assert property (  // [RQ5]
    lkRes.errExtract |-> lkRes.vld && !lkRes.frmValid)
    else $error("Error extraction of a valid frame");
  AST_RX_COUNT: assert property (  // [RQ18]
    frmOk && !lkReq.txDir && isRep |=> rxLoss_q[lkRes.peerIdx]
      == lkRes.fieldVal + 32'h0000_0001)
    else $error("Rx loss counter not incremented after sample");
  AST_BUS_ACK: assert property (
    wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
    else $error("Bus ack not a single cycle after strobe");

endmodule

// ---- tb/slm_pipe_model.sv ----
/*
  Frame pipeline model: issues one lookup at a time toward the endpoint
  and captures the result. Assumes the endpoint answers on clk_sys.
*/
`timescale 1ns/10ps

module slm_pipe_model (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Bench side
  input  wire logic              fire,
  input  wire slm_pkg::slm_req_s reqIn,
  output slm_pkg::slm_res_s      resQ,
  output logic [7:0]             resCnt,
  output logic [7:0]             lateCnt,
  // Endpoint side
  output slm_pkg::slm_req_s      lkReq,
  input  wire slm_pkg::slm_res_s lkRes
);
  logic pendQ;

  // ==========================================================================
  // Request launch
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lkReq <= '0;
    end else if (fire) begin
      lkReq <= {1'b1, reqIn[$bits(slm_pkg::slm_req_s)-2:0]};
    end else begin
      // Idle fields scramble so a stale frame is never mistaken for a live one
      lkReq <= {1'b0, ~lkReq[$bits(slm_pkg::slm_req_s)-2:0]};
    end
  end

  // ==========================================================================
  // Result capture; a result off its one-cycle slot is counted
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pendQ   <= 1'b0;
      resQ    <= '0;
      resCnt  <= 8'h00;
      lateCnt <= 8'h00;
    end else begin
      pendQ <= lkReq.vld;
      if (lkRes.vld !== pendQ) lateCnt <= lateCnt + 8'h01;
      if (lkRes.vld === 1'b1) begin
        resQ   <= lkRes;
        resCnt <= resCnt + 8'h01;
      end
    end
  end
endmodule

// ---- tb/slm_endpoint_bench.sv ----
/*
  Self-checking bench for the loss measurement endpoint: table of lookups,
  then register and corner tests. Assumes the pipeline model beside it.
*/
`timescale 1ns/10ps

module slm_endpoint_bench;
  logic clk_sys, rst_n, wbCyc, wbStb, wbWe, wbAck, fire;
  logic [7:0] wbAdr, resCnt, lateCnt;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR;
  slm_pkg::slm_req_s lkReq, reqIn, rowReq [16];
  slm_pkg::slm_res_s lkRes, resQ, rowRes [16];
  logic rowV [16];
  logic [2:0] rowIdx [16];
  logic [31:0] rowVal [16];
  int errors, checked, nRow;

  slm_endpoint u_slm_endpoint (.clk_sys(clk_sys), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
    .wbAck(wbAck), .lkReq(lkReq), .lkRes(lkRes));
  slm_pipe_model u_slm_pipe_model (.clk_sys(clk_sys), .rst_n(rst_n), .fire(fire),
    .reqIn(reqIn), .resQ(resQ), .resCnt(resCnt), .lateCnt(lateCnt), .lkReq(lkReq),
    .lkRes(lkRes));

  // ==========================================================================
  // Clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    stop_test();
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    // An expected value holding X means the field is free in that case
    if (^exp !== 1'bx) begin
      checked++;
      if (seen !== exp) begin
        errors++;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_sys);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW, wbSel} <= {1'b1, 1'b1, we, a, d, 4'hF};
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk_sys);
    end while (wbAck !== 1'b1);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask
  function automatic slm_pkg::slm_req_s mk(logic tx, slm_pkg::slm_pdu_e p, logic [2:0] pr,
                                           logic [12:0] s, logic [12:0] r, logic [31:0] t);
    return '{vld: 1'b1, txDir: tx, pdu: p, prio: pr, srcId: s, rspId: r, testId: t};
  endfunction
  task automatic look(input slm_pkg::slm_req_s r);
    logic [7:0] c0;
    int n;
    c0 = resCnt;
    fire  <= 1'b1;
    reqIn <= r;
    @(posedge clk_sys);
    fire <= 1'b0;
    n = 0;
    while (resCnt === c0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic add(input slm_pkg::slm_req_s r, input logic v, input logic [2:0] ix,
                     input logic [31:0] val);
    rowReq[nRow] = r;
    rowV[nRow]   = v;
    rowIdx[nRow] = ix;
    rowVal[nRow] = val;
    nRow++;
  endtask
  task automatic stop_test;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {rst_n, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW, fire} = '0;
    reqIn = '0;
    {errors, checked, nRow} = '0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(slm_pkg::OFF_CTRL, 32'h0000_0000);
    rd(slm_pkg::OFF_TXFRMCNT, 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000);
    $display("test reset done");
    wr(slm_pkg::OFF_CTRL, 32'h0000_03FF);
    wr(slm_pkg::OFF_SESSION, 32'h0123_0003);
    wr(slm_pkg::OFF_TESTID, 32'hCAFE_0001);
    wr(slm_pkg::OFF_PEER + 8'h08, 32'h0001_0055);
    wr(slm_pkg::OFF_PEER + 8'h14, 32'h0001_00AA);
    wr(slm_pkg::OFF_PEER, 32'h0000_0077);
    add(mk(1'b1, slm_pkg::SLM_PDU_REQ, 3'h3, 13'h0, 13'h0, 32'h0), 1'b1, 3'hX, 32'h0);
    add(mk(1'b1, slm_pkg::SLM_PDU_REQ, 3'h3, 13'h0, 13'h0, 32'h0), 1'b1, 3'hX, 32'h1);
    add(mk(1'b1, slm_pkg::SLM_PDU_REQ, 3'h2, 13'h0, 13'h0, 32'h0), 1'b0, 3'hX, 32'hX);
    add(mk(1'b1, slm_pkg::SLM_PDU_ONE, 3'h3, 13'h0, 13'h0, 32'h0), 1'b1, 3'hX, 32'h2);
    add(mk(1'b1, slm_pkg::SLM_PDU_REP, 3'h3, 13'h55, 13'h0, 32'h0), 1'b1, 3'h2, 32'h0);
    add(mk(1'b1, slm_pkg::SLM_PDU_REP, 3'h3, 13'h55, 13'h0, 32'h0), 1'b1, 3'h2, 32'h1);
    add(mk(1'b1, slm_pkg::SLM_PDU_REP, 3'h3, 13'h77, 13'h0, 32'h0), 1'b0, 3'hX, 32'hX);
    add(mk(1'b0, slm_pkg::SLM_PDU_REQ, 3'h3, 13'hAA, 13'h0, 32'h0), 1'b1, 3'h5, 32'hX);
    add(mk(1'b0, slm_pkg::SLM_PDU_REQ, 3'h3, 13'h99, 13'h0, 32'h0), 1'b0, 3'hX, 32'hX);
    add(mk(1'b0, slm_pkg::SLM_PDU_REP, 3'h3, 13'h123, 13'h55, 32'hCAFE_0001), 1'b1, 3'h2, 32'h0);
    add(mk(1'b0, slm_pkg::SLM_PDU_REP, 3'h3, 13'h123, 13'h55, 32'hCAFE_0001), 1'b1, 3'h2, 32'h1);
    add(mk(1'b0, slm_pkg::SLM_PDU_REP, 3'h3, 13'h123, 13'h55, 32'hCAFE_0002), 1'b0, 3'hX, 32'hX);
    add(mk(1'b0, slm_pkg::SLM_PDU_REP, 3'h3, 13'h124, 13'h55, 32'hCAFE_0001), 1'b0, 3'hX, 32'hX);
    add(mk(1'b0, slm_pkg::SLM_PDU_ONE, 3'h3, 13'h55, 13'h0, 32'h0), 1'b1, 3'h2, 32'h2);
    add(mk(1'b0, slm_pkg::SLM_PDU_ONE, 3'h1, 13'h55, 13'h0, 32'h0), 1'b0, 3'hX, 32'hX);
    for (int i = 0; i < nRow; i++) begin
      look(rowReq[i]);
      rowRes[i] = resQ;
      chk(32'(resQ.frmValid), 32'(rowV[i]));
      chk(32'(resQ.errExtract), 32'(!rowV[i]));
      if (rowV[i]) chk(32'(resQ.peerIdx), 32'(rowIdx[i]));
      if (rowV[i]) chk(resQ.fieldVal, rowVal[i]);
    end
    chk(32'(rowRes[0].fieldWr), 32'h1);
    chk({31'h0, rowRes[4].rspWr} << 13 | 32'(rowRes[4].rspId), 32'h0000_2123);
    chk(32'({rowRes[7].loopInject, rowRes[7].cpuCopy}), 32'h3);
    chk(32'({rowRes[9].rewrite, rowRes[9].tlvOffset, rowRes[9].endTlv}), 32'h0001_1400);
    chk(32'(rowRes[9].cpuCopy), 32'h1);
    $display("test lookup table done");
    rd(slm_pkg::OFF_STICKY, 32'h0000_00FF);
    wr(slm_pkg::OFF_STICKY, 32'h0000_00FF);
    rd(slm_pkg::OFF_STICKY, 32'h0000_0000);
    rd(slm_pkg::OFF_TXFRMCNT, 32'h0000_0003);
    rd(slm_pkg::OFF_TXLOSS + 8'h08, 32'h0000_0002);
    rd(slm_pkg::OFF_RXLOSS + 8'h08, 32'h0000_0003);
    rd(slm_pkg::OFF_OAMTX, 32'h0000_0005);
    rd(slm_pkg::OFF_OAMRX, 32'h0000_0004);
    $display("test counters done");
    wr(slm_pkg::OFF_CTRL, 32'h0000_03FD);
    look(mk(1'b1, slm_pkg::SLM_PDU_REQ, 3'h3, 13'h0, 13'h0, 32'h0));
    chk(32'({resQ.frmValid, resQ.fieldWr}), 32'h2);
    rd(slm_pkg::OFF_TXFRMCNT, 32'h0000_0004);
    wr(slm_pkg::OFF_TXFRMCNT, 32'hFFFF_FFFF);
    wr(slm_pkg::OFF_CTRL, 32'h0000_037F);
    look(mk(1'b1, slm_pkg::SLM_PDU_REQ, 3'h3, 13'h0, 13'h0, 32'h0));
    chk(resQ.fieldVal, 32'hFFFF_FFFF);
    rd(slm_pkg::OFF_TXFRMCNT, 32'h0000_0000);
    $display("test wrap done");
    wr(slm_pkg::OFF_EXTRACT, 32'h0000_0104);
    look(mk(1'b0, slm_pkg::SLM_PDU_ONE, 3'h3, 13'h55, 13'h0, 32'h0));
    chk(32'(resQ.cpuCopy), 32'h1);
    rd(slm_pkg::OFF_EXTRACT, 32'h0000_0100);
    look(mk(1'b0, slm_pkg::SLM_PDU_ONE, 3'h3, 13'h55, 13'h0, 32'h0));
    chk(32'(resQ.cpuCopy), 32'h0);
    $display("test first hit extract done");
    wr(slm_pkg::OFF_CTRL, 32'h0000_0000);
    look(mk(1'b1, slm_pkg::SLM_PDU_REQ, 3'h3, 13'h0, 13'h0, 32'h0));
    chk(32'({resQ.frmValid, resQ.errExtract}), 32'h0);
    rd(slm_pkg::OFF_TXFRMCNT, 32'h0000_0000);
    chk(32'(lateCnt), 32'h0);
    $display("test disabled done");
    stop_test();
  end
endmodule
